// *** ser_regs.vh ***
`ifndef SER_REGS_VH
`define SER_REGS_VH

// Parallel word width
`define WORD_BITS        24
// Serial frame: start clock bit, data bits, stop clock bit
`define FRAME_BITS       26
`define FRAME_CNT_BITS   5
// Embedded clock bit levels
`define CLK_BIT_START    1'b1
`define CLK_BIT_STOP     1'b0
// Selected parallel clock edges before the capture path counts as locked
`define LOCK_EDGES       8
`define LOCK_CNT_BITS    4
// Slowest parallel clock period and system clock period, in ns
`define PCLK_MAX_PERIOD_NS  200
`define SYS_PERIOD_NS       8
// Loss of parallel clock: two slowest periods without an edge
`define LOSS_TIME_NS     (2 * `PCLK_MAX_PERIOD_NS)
`define LOSS_CYCLES      (`LOSS_TIME_NS / `SYS_PERIOD_NS)
`define LOSS_CNT_BITS    7
// Lock state codes
`define LK_OFF           2'h0
`define LK_ACQ           2'h1
`define LK_ON            2'h2

`endif

// *** ser_shift.v ***
`include "ser_regs.vh"

module ser_shift #(
	parameter WORD_BITS  = `WORD_BITS,
	parameter FRAME_BITS = `FRAME_BITS
) (
	// Clock and reset
	input  wire                 clock,
	input  wire                 srst,
	// Abort any frame in flight
	input  wire                 flush,
	// Word to send
	input  wire                 load,
	input  wire [WORD_BITS-1:0] word,
	// Serial side
	output reg                  busy_r,
	output wire                 bit_out
);

	reg [FRAME_BITS-1:0]      shift_r;
	reg [`FRAME_CNT_BITS-1:0] cnt_r;

	// LSB leaves first: start bit, data bit 0 upward, stop bit
	assign bit_out = shift_r[0];

	// Load one framed word and shift it out one bit per clock
	always @(posedge clock) begin
		if (srst || flush) begin
			shift_r <= {FRAME_BITS{1'b0}};
			cnt_r   <= {`FRAME_CNT_BITS{1'b0}};
			busy_r  <= 1'b0;
		end else if (load && !busy_r) begin
			shift_r <= {`CLK_BIT_STOP, word, `CLK_BIT_START};
			cnt_r   <= FRAME_BITS[`FRAME_CNT_BITS-1:0] - 5'h01;
			busy_r  <= 1'b1;
		end else if (busy_r) begin
			shift_r <= {1'b0, shift_r[FRAME_BITS-1:1]};
			cnt_r   <= cnt_r - 5'h01;
			if (cnt_r == {`FRAME_CNT_BITS{1'b0}})
				busy_r <= 1'b0;
		end
	end

endmodule

// *** ser_input_control.v ***
// How it works
// - Capture on rising or falling edge select
// - Sleep low stops PLL, floats outputs
// - Sleep high: device runs normally
// - Drive enable high drives serial outputs while sleep is high
// - Drive enable low floats, PLL stays locked
`include "ser_regs.vh"

module ser_input_control #(
	parameter WORD_BITS  = `WORD_BITS,
	parameter LOCK_EDGES = `LOCK_EDGES
) (
	// Clock and reset
	input  wire                 clock,
	input  wire                 srst,
	// Parallel input pins
	input  wire                 parallel_clock_in,
	input  wire [WORD_BITS-1:0] parallel_data_in,
	// Static control pins
	input  wire                 tx_sleep_n,
	input  wire                 serial_drive_enable,
	input  wire                 capture_edge_select,
	input  wire                 swing_level_select,
	// Serial differential output, three-state
	output reg                  serial_out_p_r,
	output reg                  serial_out_n_r,
	output reg                  serial_out_oe_r,
	output reg                  swing_high_r,
	// Status
	output reg                  pll_locked_r,
	output reg                  word_overrun_r
);

	localparam LOSS_CYCLES = `LOSS_CYCLES;

	// Two-flop synchronisers for every pin
	reg                 pclk_s1_r;
	reg                 pclk_s2_r;
	reg                 pclk_s3_r;
	reg [WORD_BITS-1:0] din_s1_r;
	reg [WORD_BITS-1:0] din_s2_r;
	reg [3:0]           ctl_s1_r;
	reg [3:0]           ctl_s2_r;

	// Lock tracking
	reg [1:0]                 lk_state_r;
	reg [1:0]                 lk_state_nxt;
	reg [`LOCK_CNT_BITS-1:0]  lk_cnt_r;
	reg [`LOCK_CNT_BITS-1:0]  lk_cnt_nxt;
	reg [`LOSS_CNT_BITS-1:0]  loss_cnt_r;

	// Word hand-off
	reg [WORD_BITS-1:0] hold_r;
	reg                 hold_valid_r;

	wire                sleep_n_s;
	wire                drive_en_s;
	wire                edge_sel_s;
	wire                swing_s;
	wire                rise;
	wire                fall;
	wire                any_edge;
	wire                cap;
	wire                clk_lost;
	wire                ser_busy;
	wire                ser_bit;
	wire                ser_load;

	assign sleep_n_s  = ctl_s2_r[0];
	assign drive_en_s = ctl_s2_r[1];
	assign edge_sel_s = ctl_s2_r[2];
	assign swing_s    = ctl_s2_r[3];

	// Pins pass two flops; third clock flop only feeds edge detect
	always @(posedge clock) begin
		if (srst) begin
			pclk_s1_r <= 1'b0;
			pclk_s2_r <= 1'b0;
			pclk_s3_r <= 1'b0;
			din_s1_r  <= {WORD_BITS{1'b0}};
			din_s2_r  <= {WORD_BITS{1'b0}};
			ctl_s1_r  <= 4'h0;
			ctl_s2_r  <= 4'h0;
		end else begin
			pclk_s1_r <= parallel_clock_in;
			pclk_s2_r <= pclk_s1_r;
			pclk_s3_r <= pclk_s2_r;
			din_s1_r  <= parallel_data_in;
			din_s2_r  <= din_s1_r;
			ctl_s1_r  <= {swing_level_select, capture_edge_select,
				serial_drive_enable, tx_sleep_n};
			ctl_s2_r  <= ctl_s1_r;
		end
	end

	// Edge detection on the synchronised parallel clock
	assign rise     = pclk_s2_r & ~pclk_s3_r;
	assign fall     = ~pclk_s2_r & pclk_s3_r;
	assign any_edge = rise | fall;
	assign cap      = edge_sel_s ? rise : fall;
	assign clk_lost = (loss_cnt_r == LOSS_CYCLES[`LOSS_CNT_BITS-1:0]);

	// Watchdog on the parallel clock; held at zero while asleep
	always @(posedge clock) begin
		if (srst || !sleep_n_s || any_edge)
			loss_cnt_r <= {`LOSS_CNT_BITS{1'b0}};
		else if (!clk_lost)
			loss_cnt_r <= loss_cnt_r + 7'h01;
	end

	// Lock state: sleep shuts it off, drive enable plays no part
	always @* begin
		lk_state_nxt = lk_state_r;
		lk_cnt_nxt   = lk_cnt_r;
		case (lk_state_r)
		`LK_OFF: begin
			lk_cnt_nxt = {`LOCK_CNT_BITS{1'b0}};
			if (sleep_n_s)
				lk_state_nxt = `LK_ACQ;
		end
		`LK_ACQ: begin
			if (cap)
				lk_cnt_nxt = lk_cnt_r + 4'h1;
			if (cap && lk_cnt_r ==
				LOCK_EDGES[`LOCK_CNT_BITS-1:0] - 4'h1)
				lk_state_nxt = `LK_ON;
			if (clk_lost)
				lk_cnt_nxt = {`LOCK_CNT_BITS{1'b0}};
		end
		`LK_ON: begin
			if (clk_lost) begin
				lk_state_nxt = `LK_ACQ;
				lk_cnt_nxt   = {`LOCK_CNT_BITS{1'b0}};
			end
		end
		default: begin
			lk_state_nxt = `LK_OFF;
		end
		endcase
		if (!sleep_n_s) begin
			lk_state_nxt = `LK_OFF;
			lk_cnt_nxt   = {`LOCK_CNT_BITS{1'b0}};
		end
	end

	// Lock state registers
	always @(posedge clock) begin
		if (srst) begin
			lk_state_r <= `LK_OFF;
			lk_cnt_r   <= {`LOCK_CNT_BITS{1'b0}};
		end else begin
			lk_state_r <= lk_state_nxt;
			lk_cnt_r   <= lk_cnt_nxt;
		end
	end

	// Capture one word per selected edge once locked
	assign ser_load = hold_valid_r && !ser_busy;

	always @(posedge clock) begin
		if (srst || lk_state_r != `LK_ON) begin
			hold_r         <= {WORD_BITS{1'b0}};
			hold_valid_r   <= 1'b0;
			word_overrun_r <= 1'b0;
		end else begin
			word_overrun_r <= cap && hold_valid_r && !ser_load;
			if (cap) begin
				hold_r       <= din_s2_r;
				hold_valid_r <= 1'b1;
			end else if (ser_load) begin
				hold_valid_r <= 1'b0;
			end
		end
	end

	// Frame shifter, aborted whenever lock is lost
	ser_shift #(
		.WORD_BITS  (WORD_BITS),
		.FRAME_BITS (`FRAME_BITS)
	) u_shift (
		.clock   (clock),
		.srst    (srst),
		.flush   (lk_state_r != `LK_ON),
		.load    (ser_load),
		.word    (hold_r),
		.busy_r  (ser_busy),
		.bit_out (ser_bit)
	);

	// Registered pin outputs
	always @(posedge clock) begin
		if (srst) begin
			serial_out_p_r  <= 1'b0;
			serial_out_n_r  <= 1'b1;
			serial_out_oe_r <= 1'b0;
			swing_high_r    <= 1'b0;
			pll_locked_r    <= 1'b0;
		end else begin
			serial_out_p_r  <= ser_bit;
			serial_out_n_r  <= ~ser_bit;
			serial_out_oe_r <= sleep_n_s & drive_en_s;
			swing_high_r    <= swing_s;
			pll_locked_r    <= (lk_state_nxt == `LK_ON);
		end
	end

endmodule

// *** ser_ic_asserts.sv ***
module ser_ic_asserts (
	// Clock and reset
	input wire clock,
	input wire srst,
	// Control pins
	input wire tx_sleep_n,
	input wire serial_drive_enable,
	input wire swing_level_select,
	// Serial side and status
	input wire serial_out_p_r,
	input wire serial_out_n_r,
	input wire serial_out_oe_r,
	input wire swing_high_r,
	input wire pll_locked_r
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	// Pin changes reach oe, swing and lock three cycles later and the serial pair five, so six gives margin
	AST_SLEEP_OE: assert property (!tx_sleep_n[*6] |-> !serial_out_oe_r)
		else $error("pair driven while asleep");
	AST_SLEEP_LOCK: assert property (!tx_sleep_n[*6] |->
		!pll_locked_r && !serial_out_p_r)
		else $error("lock or frame kept while asleep");
	AST_RUN_OE: assert property ((tx_sleep_n && serial_drive_enable)[*6]
		|-> serial_out_oe_r)
		else $error("pair not driven while enabled");
	AST_DEN_OFF: assert property (!serial_drive_enable[*6] |->
		!serial_out_oe_r)
		else $error("pair driven with drive enable low");
	AST_PAIR: assert property (serial_out_n_r != serial_out_p_r)
		else $error("pair not complementary");
	AST_SWING: assert property (swing_level_select[*6] |-> swing_high_r)
		else $error("swing select not followed");
endmodule

// *** host_model.sv ***
module host_model (
	// Clock and stimulus
	input  wire        clock,
	input  wire        run,
	input  wire        fast,
	input  wire        capture_edge_select,
	input  wire [23:0] word,
	// Parallel pins
	output logic        parallel_clock_in,
	output logic [23:0] parallel_data_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] cnt_r = 5'h00;
	logic [4:0] last;
	logic [4:0] mid;
	initial parallel_clock_in = 1'b0;
	initial parallel_data_in = 24'h000000;
	// Half period of 20 cycles, or 5 when fast; still while idle
	assign last = fast ? 5'h04 : 5'h13;
	assign mid  = fast ? 5'h02 : 5'h09;
	// Word stands only around the selected edge, its inverse around
	// the other edge, so a capture on the wrong edge is seen
	always @(posedge clock) begin
		cnt_r <= (run && cnt_r < last) ? cnt_r + 5'h01 : 5'h00;
		if (run && cnt_r >= last)
			parallel_clock_in <= !parallel_clock_in;
		if (run && cnt_r == mid)
			parallel_data_in <= (parallel_clock_in == capture_edge_select)
				? ~word : word;
	end
endmodule

// *** tb_top.sv ***
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 0, srst = 1, run = 0, tx_sleep_n = 1, fast = 0;
	logic serial_drive_enable = 1, capture_edge_select = 1;
	logic swing_level_select = 0;
	logic [23:0] word = 24'h000000, parallel_data_in;
	logic parallel_clock_in, serial_out_p_r, serial_out_n_r;
	logic serial_out_oe_r, swing_high_r, pll_locked_r, word_overrun_r;
	int error_cnt = 0, samples_checked = 0, cyc = 0, ovr_seen = 0;
	always #4 clock = ~clock;
	host_model i_host_model (.clock, .run, .fast, .capture_edge_select,
		.word, .parallel_clock_in, .parallel_data_in);
	ser_input_control #(.LOCK_EDGES(2)) i_ser_input_control (.clock,
		.srst, .parallel_clock_in, .parallel_data_in, .tx_sleep_n,
		.serial_drive_enable, .capture_edge_select, .swing_level_select,
		.serial_out_p_r, .serial_out_n_r, .serial_out_oe_r, .swing_high_r,
		.pll_locked_r, .word_overrun_r);
	// Overrun pulses, counted while they stand
	always @(posedge clock)
		if (word_overrun_r === 1'b1)
			ovr_seen++;
	task automatic check(string what, logic [23:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic close_out;
		$display("checked %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Words hold no run of five zeros, so five zeros mark the gap
	task automatic frame(logic sel, logic [23:0] w);
		int z;
		logic [23:0] got;
		@(posedge clock);
		capture_edge_select <= sel;
		word <= w;
		run <= 1;
		repeat (300) @(negedge clock);
		z = 0;
		while (z < 5) begin
			@(negedge clock);
			z = serial_out_p_r ? 0 : z + 1;
		end
		while (!serial_out_p_r)
			@(negedge clock);
		for (int i = 0; i < 24; i++) begin
			@(negedge clock);
			got[i] = serial_out_p_r;
		end
		@(negedge clock);
		check("frame", got, w);
		check("stop", serial_out_p_r, 0);
	endtask
	// Drive enable low floats the pair but keeps lock
	task automatic den_off;
		@(posedge clock);
		serial_drive_enable <= 0;
		repeat (100) @(negedge clock);
		check("oe den", serial_out_oe_r, 0);
		check("lock den", pll_locked_r, 1);
		@(posedge clock);
		serial_drive_enable <= 1;
	endtask
	// Sleep floats the pair, drops lock and stops the frame
	task automatic sleep;
		@(posedge clock);
		tx_sleep_n <= 0;
		repeat (10) @(negedge clock);
		check("oe sleep", serial_out_oe_r, 0);
		check("lock sleep", pll_locked_r, 0);
		check("p sleep", serial_out_p_r, 0);
		@(posedge clock);
		tx_sleep_n <= 1;
	endtask
	// A 10-cycle parallel clock outruns the 26-bit frame
	task automatic overrun;
		check("no overrun", ovr_seen, 0);
		@(posedge clock);
		fast <= 1;
		repeat (200) @(negedge clock);
		check("overrun", ovr_seen != 0, 1);
		check("lock fast", pll_locked_r, 1);
	endtask
	// A stopped parallel clock drops lock and aborts the frame
	task automatic clock_stop;
		@(posedge clock);
		run <= 0;
		repeat (100) @(negedge clock);
		check("lock stop", pll_locked_r, 0);
		check("p stop", serial_out_p_r, 0);
	endtask
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			close_out;
		end
	end
	initial begin
		repeat (10) @(posedge clock);
		srst <= 0;
		frame(1, 24'h6DB6DB);
		@(posedge clock);
		swing_level_select <= 1;
		frame(0, 24'hB6DB6D);
		check("swing", swing_high_r, 1);
		check("oe run", serial_out_oe_r, 1);
		den_off;
		sleep;
		// Relock and a 300-cycle wait resynchronise before data is judged
		frame(1, 24'hDB6DB6);
		overrun;
		clock_stop;
		close_out;
	end
endmodule
bind ser_input_control ser_ic_asserts i_ser_ic_asserts (.clock, .srst,
	.tx_sleep_n, .serial_drive_enable, .swing_level_select, .serial_out_p_r,
	.serial_out_n_r, .serial_out_oe_r, .swing_high_r, .pll_locked_r);
